// ### logic/rtcsp_host.sv
// Host controller driving the four-wire serial port of the clock chip
// What this block does
// - Session runs from CE rise to fall.
// - Control byte: address nibble, format nibble.
// - Every byte moves MSB first.
// - Code 8h single write, 0h burst.
// - Code Ch single read, 4h burst.
// - CE high stays under one second.
// - CE drops when the high-time limit is hit.
// - Whole time access in one session.
// - Wait 31 us when the session's first byte targets time registers.
// - CE low at least 62 us between sessions.
// - Setup wait may be skipped when carry-free.
module rtcsp_host #(
	parameter int MAX_HIGH = rtcsp_pkg::MAX_HIGH_CYC,
	parameter int SETUP    = rtcsp_pkg::SETUP_CYC,
	parameter int GAP      = rtcsp_pkg::GAP_CYC
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        cmdValid,
	output logic             cmdReady,
	input  wire logic [3:0]  cmdAddr,
	input  wire logic [3:0]  cmdFmt,
	input  wire logic [7:0]  cmdWdata,
	input  wire logic        cmdLast,
	input  wire logic        cmdSkipTiming,
	input  wire logic        clkIdleHigh,
	output logic [7:0]       rdData_q,
	output logic             rdValid_q,
	output logic             timeout_q,
	output logic             chipEn_q,
	output logic             serClk_q,
	output logic             serIn_q,
	input  wire logic        serOut
);
	import rtcsp_pkg::*;

	initial begin
		if (MAX_HIGH < 1 || SETUP < 1 || GAP < 1)
			$error("rtcsp_host: timing counts must be at least one");
	end

	rtcsp_state_t state_q;
	logic [31:0]  cnt_q;       // Setup and gap counter
	logic [31:0]  highCnt_q;
	logic [3:0]   half_q;      // Serial clock half-period divider
	logic [3:0]   bitCnt_q;
	logic [7:0]   shift_q;
	logic [7:0]   rxShift_q;
	logic [3:0]   addr_q;
	logic [3:0]   fmt_q;
	logic         idleHigh_q;
	logic         last_q;
	logic         skip_q;
	logic [1:0]   soSync_q;    // Two-stage synchroniser for the returned data
	logic         isRead;
	logic         halfDone;
	logic         leadEdge;

	assign isRead   = fmt_q[FMT_READ_BIT];
	assign halfDone = (half_q == 4'(HALF_CYC - 1));
	// Leading edge moves the clock away from its idle level, the device drives there
	assign leadEdge = halfDone && (serClk_q == idleHigh_q);
	// A session marked last is released in NEXT, so no byte may be taken there
	assign cmdReady = (state_q == RTCSP_IDLE)
		|| (state_q == RTCSP_NEXT && !last_q);

	function automatic logic burstFmt(input logic [3:0] f);
		return (f == FMT_WRITE_BURST) || (f == FMT_READ_BURST);
	endfunction

	// Bit of a byte at a given position of the MSB-first stream
	function automatic logic bitAt(input logic [7:0] b, input logic [3:0] n);
		return b[3'(ADDR_MSB) - n[2:0]];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Cycles with CE low, saturating; only the gap check reads it
	logic [31:0] lowCnt_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) lowCnt_q <= 32'h0;
		else if (chipEn_q) lowCnt_q <= 32'h0;
		else if (lowCnt_q != 32'hffff_ffff) lowCnt_q <= lowCnt_q + 32'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Returned data crosses from the pin domain
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) soSync_q <= 2'h0;
		else soSync_q <= {soSync_q[0], serOut};
	end

	////////////////////////////////////////////////////////////////////////////
	// Session sequencer; the idle clock level picks the device's edge choice
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q    <= RTCSP_GAP;
			cnt_q      <= 32'h0;
			highCnt_q  <= 32'h0;
			half_q     <= 4'h0;
			bitCnt_q   <= 4'h0;
			shift_q    <= 8'h00;
			rxShift_q  <= 8'h00;
			addr_q     <= 4'h0;
			fmt_q      <= 4'h0;
			idleHigh_q <= 1'b0;
			last_q     <= 1'b0;
			skip_q     <= 1'b0;
			chipEn_q   <= 1'b0;
			serClk_q   <= 1'b0;
			serIn_q    <= 1'b0;
			rdData_q   <= 8'h00;
			rdValid_q  <= 1'b0;
			timeout_q  <= 1'b0;
		end else begin
			rdValid_q <= 1'b0;
			if (chipEn_q) highCnt_q <= highCnt_q + 32'h1;
			else highCnt_q <= 32'h0;
			// Carry hold lasts at most a second, so a stuck session is cut off
			if (chipEn_q && highCnt_q >= 32'(MAX_HIGH - 1)) begin
				timeout_q <= 1'b1;
				chipEn_q  <= 1'b0;
				serClk_q  <= idleHigh_q;
				cnt_q     <= 32'h0;
				state_q   <= RTCSP_GAP;
			end else begin
				unique case (state_q)
				RTCSP_GAP: begin
					// Minimum CE low time lets a deferred carry land
					if (cnt_q >= 32'(GAP - 1)) state_q <= RTCSP_IDLE;
					else cnt_q <= cnt_q + 32'h1;
				end
				RTCSP_IDLE: begin
					serClk_q <= clkIdleHigh;
					if (cmdValid) begin
						timeout_q  <= 1'b0;
						idleHigh_q <= clkIdleHigh;
						serClk_q   <= clkIdleHigh;
						chipEn_q   <= 1'b1;
						addr_q     <= cmdAddr;
						fmt_q      <= cmdFmt;
						last_q     <= cmdLast;
						skip_q     <= cmdSkipTiming;
						shift_q    <= cmdWdata;
						cnt_q      <= 32'h0;
						state_q    <= RTCSP_SETUP;
					end
				end
				RTCSP_SETUP: begin
					// Time registers wait for any running carry unless carry-free
					if (skip_q || addr_q > TIME_ADDR_LAST
						|| cnt_q >= 32'(SETUP - 1)) begin
						state_q  <= RTCSP_CTRL;
						bitCnt_q <= 4'h0;
						half_q   <= 4'h0;
						serIn_q  <= addr_q[3];
					end else cnt_q <= cnt_q + 32'h1;
				end
				RTCSP_CTRL, RTCSP_DATA: begin
					half_q <= halfDone ? 4'h0 : half_q + 4'h1;
					if (halfDone) begin
						serClk_q <= ~serClk_q;
						if (leadEdge) begin
							// Data moves on the edge the device does not sample,
							// so it is never racing the device's capture
							if (state_q == RTCSP_CTRL)
								serIn_q <= bitAt({addr_q, fmt_q}, bitCnt_q);
							else if (!isRead)
								serIn_q <= bitAt(shift_q, bitCnt_q);
							else serIn_q <= 1'b0;
						end else begin
							// Trailing edge: device samples, we shift and count
							bitCnt_q  <= bitCnt_q + 4'h1;
							rxShift_q <= {rxShift_q[6:0], soSync_q[1]};
							if (bitCnt_q == 4'(BYTE_BITS - 1)) begin
								bitCnt_q <= 4'h0;
								if (state_q == RTCSP_CTRL) begin
									state_q <= RTCSP_DATA;
								end else begin
									if (isRead) begin
										rdData_q  <= {rxShift_q[6:0], soSync_q[1]};
										rdValid_q <= 1'b1;
									end
									if (burstFmt(fmt_q)) addr_q <= addr_q + 4'h1;
									state_q <= RTCSP_NEXT;
								end
							end
						end
					end
				end
				RTCSP_NEXT: begin
					// Another byte, a fresh control byte, or CE release
					if (last_q) begin
						chipEn_q <= 1'b0;
						cnt_q    <= 32'h0;
						state_q  <= RTCSP_GAP;
					end else if (cmdValid) begin
						last_q  <= cmdLast;
						shift_q <= cmdWdata;
						half_q  <= 4'h0;
						if (burstFmt(fmt_q)) begin
							state_q <= RTCSP_DATA;
							serIn_q <= isRead ? 1'b0 : cmdWdata[ADDR_MSB];
						end else begin
							addr_q  <= cmdAddr;
							fmt_q   <= cmdFmt;
							serIn_q <= cmdAddr[3];
							state_q <= RTCSP_CTRL;
						end
					end
				end
				default: state_q <= RTCSP_GAP;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks on the pin sequence, the burst address step and the command handshake
	chk_clk_idle_ce: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(chipEn_q) |-> serClk_q == idleHigh_q)
		else $error("serial clock not at idle level at CE rise");
	chk_ce_gap_min: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(chipEn_q) |-> lowCnt_q >= 32'(GAP))
		else $error("CE low interval too short");
	chk_burst_wrap: assert property (@(posedge clk) disable iff (!arst_n)
		(state_q == RTCSP_DATA && halfDone && !leadEdge && bitCnt_q == 4'h7
		&& burstFmt(fmt_q)) |=> addr_q == $past(addr_q) + 4'h1)
		else $error("burst address did not advance");
	chk_high_limit: assert property (@(posedge clk) disable iff (!arst_n)
		chipEn_q |-> highCnt_q < 32'(MAX_HIGH))
		else $error("CE held high too long");
	chk_si_at_sample: assert property (@(posedge clk) disable iff (!arst_n)
		(chipEn_q && $changed(serClk_q) && serClk_q == idleHigh_q) |-> $stable(serIn_q))
		else $error("serial input moved at the device sampling edge");
	chk_last_no_take: assert property (@(posedge clk) disable iff (!arst_n)
		(state_q == RTCSP_NEXT && last_q) |-> !cmdReady)
		else $error("byte offered while the session is being released");
endmodule

// ### logic/rtcsp_pkg.sv
// Constants shared by the serial-port host controller
package rtcsp_pkg;
	// Transfer-format codes, low nibble of the control byte
	localparam logic [3:0] FMT_WRITE_ONE   = 4'h8;
	localparam logic [3:0] FMT_WRITE_BURST = 4'h0;
	localparam logic [3:0] FMT_READ_ONE    = 4'hc;
	localparam logic [3:0] FMT_READ_BURST  = 4'h4;
	localparam int BYTE_BITS  = 8;
	localparam int ADDR_MSB   = 7;  // Address nibble sits in bits 7..4
	localparam int FMT_READ_BIT = 2; // Set for either read format
	// Highest address of the clock registers that can carry
	localparam logic [3:0] TIME_ADDR_LAST = 4'h6;
	// Host timing, in nanoseconds, and the clock period
	localparam int CLK_PERIOD_NS = 5;
	localparam int SETUP_NS      = 31000; // CE high before time access
	localparam int GAP_NS        = 62000; // CE low between sessions
	localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest CE high interval: just under one second
	localparam int MAX_HIGH_CYC  = 199_999_000;
	// Serial clock half period in system clocks
	localparam int HALF_CYC      = 5;
	typedef enum logic [2:0] {RTCSP_IDLE, RTCSP_GAP, RTCSP_SETUP, RTCSP_CTRL,
		RTCSP_DATA, RTCSP_NEXT} rtcsp_state_t;
endpackage

// ### testbench/rtcsp_dev_model.sv
// Behavioural model of the clock chip's four-wire serial port
module rtcsp_dev_model #(
	parameter int GAP      = 4,
	parameter int MAX_HIGH = 100000
) (
	input  wire logic chipEn,
	input  wire logic serClk,
	input  wire logic serIn,
	output wire logic serOut,
	output int        viol
);
	timeunit 1ns;
	timeprecision 1ps;
	import rtcsp_pkg::*;
	logic [7:0] mem [16];
	logic [7:0] sh, rx;
	logic [3:0] ptr, fmt;
	logic       mode, ctrl, rd, drv, so;
	logic       carryHeld;  // Seconds carry is deferred while this is set
	int         nb;
	realtime    tRise, tFall;
	// Released line shows the inverse of the last bit, so stale data never matches
	assign serOut = drv ? so : ~so;
	initial begin
		viol = 0;
		tFall = 0;
		tRise = 0;
		so = 0;
		rd = 0;
		drv = 0;
		carryHeld = 0;
		for (int i = 0; i < 16; i++) mem[i] = {i[3:0], ~i[3:0]};
	end
	////////////////////////////////////////////////////////////////////////
	// Session start latches the edge mode and checks the low gap
	always @(posedge chipEn) begin
		mode = serClk;
		ctrl = 1;
		nb = 0;
		carryHeld = 1;
		if (tFall > 0 && $realtime - tFall < GAP * CLK_PERIOD_NS) viol++;
		tRise = $realtime;
	end
	// Session end releases the data line and checks the high time
	always @(negedge chipEn) begin
		rd = 0;
		drv = 0;
		carryHeld = 0; // Deferred carry lands now
		tFall = $realtime;
		if (tFall - tRise > MAX_HIGH * CLK_PERIOD_NS) viol++;
	end
	// Sample on the edge matching the latched level, drive on the other
	always @(serClk) begin
		if (chipEn === 1'b1 && serClk === mode) begin
			rx = {rx[6:0], serIn};
			nb++;
		end else if (chipEn === 1'b1 && rd) begin
			drv = 1;
			so = sh[7];
			sh = sh << 1;
		end
		if (nb == 8) begin
			nb = 0;
			if (ctrl) begin
				{ptr, fmt} = rx;
				ctrl = 0;
				rd = fmt[2];
			end else begin
				if (!rd) mem[ptr] = rx;
				if (fmt[3]) begin
					ctrl = 1;
					rd = 0;
					drv = 0;
				end else ptr++;
			end
			sh = mem[ptr];
		end
	end
endmodule

// ### testbench/tb.sv
// Self-checking bench for the serial-port host controller
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
	$display("mismatch %0t got %h want %h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rtcsp_pkg::*;
	logic       clk, arst_n, cmdValid, cmdReady, cmdLast, cmdSkipTiming, clkIdleHigh;
	logic       rdValid_q, timeout_q, chipEn_q, serClk_q, serIn_q, serOut;
	logic [3:0] cmdAddr, cmdFmt;
	logic [7:0] cmdWdata, rdData_q, expByte;
	logic [7:0] mirror [16];
	logic [7:0] expQ [$];
	int         n_fail, checks_done, viol;
	rtcsp_host #(.MAX_HIGH(100000), .SETUP(4), .GAP(4)) u_dut (.clk(clk), .arst_n(arst_n),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdAddr(cmdAddr), .cmdFmt(cmdFmt),
		.cmdWdata(cmdWdata), .cmdLast(cmdLast), .cmdSkipTiming(cmdSkipTiming),
		.clkIdleHigh(clkIdleHigh), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
		.timeout_q(timeout_q), .chipEn_q(chipEn_q), .serClk_q(serClk_q),
		.serIn_q(serIn_q), .serOut(serOut));
	rtcsp_dev_model #(.GAP(4), .MAX_HIGH(100000)) u_dev (.chipEn(chipEn_q),
		.serClk(serClk_q), .serIn(serIn_q), .serOut(serOut), .viol(viol));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task stop_test;
		if (n_fail == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Hold the request until an edge sees it taken; bounded so a hang ends the run
	task automatic send(input logic [3:0] a, input logic [3:0] f, input logic [7:0] d,
		input logic l);
		int n;
		@(posedge clk);
		cmdValid <= 1;
		cmdAddr <= a;
		cmdFmt <= f;
		cmdWdata <= d;
		cmdLast <= l;
		cmdSkipTiming <= 1'($urandom % 2);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cmdReady !== 1'b1 && n < 5000);
		cmdValid <= 0;
		if (cmdReady !== 1'b1) begin
			n_fail++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [3:0] f, input logic l);
		logic [7:0] d;
		d = 8'($urandom);
		mirror[a] = d;
		send(a, f, d, l);
	endtask
	task automatic rd(input logic [3:0] a, input logic [3:0] f, input logic l);
		expQ.push_back(mirror[a]);
		send(a, f, 8'h00, l);
	endtask
	// Wait until the session and its low gap are over, bounded
	task automatic settle;
		int n;
		for (n = 0; n < 5000 && !(chipEn_q === 1'b0 && cmdReady === 1'b1); n++) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Each returned byte is matched against the oldest note
	always @(posedge clk) begin
		if (rdValid_q === 1'b1) begin
			expByte = expQ.size() > 0 ? expQ.pop_front() : 8'hxx;
			`CHK(rdData_q, expByte)
		end
	end
	// Both edge modes, single, mixed and wrapping burst transfers
	initial begin
		arst_n = 0;
		{cmdValid, cmdAddr, cmdFmt, cmdWdata, cmdLast, cmdSkipTiming, clkIdleHigh} = '0;
		n_fail = 0;
		checks_done = 0;
		void'($urandom(32'h6ee7));
		for (int i = 0; i < 16; i++) mirror[i] = {i[3:0], ~i[3:0]};
		repeat (20) @(posedge clk);
		arst_n <= 1;
		for (int m = 0; m < 2; m++) begin
			settle();
			clkIdleHigh <= m[0];
			wr(4'h7, FMT_WRITE_ONE, 1);
			rd(4'h7, FMT_READ_ONE, 1);
			rd(4'hf, FMT_READ_ONE, 0);
			wr(4'hf, FMT_WRITE_ONE, 0);
			rd(4'hf, FMT_READ_ONE, 1);
			for (int k = 0; k < 3; k++) wr(4'he + k[3:0], FMT_WRITE_BURST, k == 2);
			for (int k = 0; k < 3; k++) rd(4'hf + k[3:0], FMT_READ_BURST, k == 2);
			settle();
		end
		for (int n = 0; n < 2000 && expQ.size() > 0; n++) @(posedge clk);
		`CHK(expQ.size(), 0)
		`CHK(viol, 0)
		`CHK(timeout_q, 1'b0)
		for (int i = 0; i < 16; i++) `CHK(u_dev.mem[i], mirror[i])
		stop_test();
	end
endmodule
